// *** hdl/flash_seq.sv ***
// erase and program command sequencer of a serial nor flash
`timescale 1ns/100ps
`include "flash_seq_defines.svh"
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter logic [7:0]  WRITE_ENABLE_OPCODE = 8'h06, // arbitrary default
  parameter logic [7:0]  LARGE_WIPE_OPCODE   = 8'hd8, // arbitrary default
  parameter logic [7:0]  ARRAY_WIPE_OPCODE   = 8'h60, // arbitrary default
  parameter int unsigned SMALL_WIPE_CYCLES   = `SMALL_WIPE_TIME_US * `REF_CLK_MHZ,
  parameter int unsigned HALF_WIPE_CYCLES    = `HALF_WIPE_TIME_US * `REF_CLK_MHZ,
  parameter int unsigned LARGE_WIPE_CYCLES   = `LARGE_WIPE_TIME_US * `REF_CLK_MHZ,
  parameter int unsigned ARRAY_WIPE_CYCLES   = `ARRAY_WIPE_TIME_US * `REF_CLK_MHZ,
  parameter int unsigned PROGRAM_CYCLES      = `PROGRAM_TIME_US * `REF_CLK_MHZ
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_lines,
  input  wire logic       four_line_enable,
  input  wire logic [4:0] protection_bits,
  output logic            busy_flag,
  output logic            write_latch,
  output logic            four_line_mode,
  output logic            cmd_reject,
  output arr_op_t         arr_op
);

  // ==========================================================================
  // functions
  // shift the sampled lanes in, msb first
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] io, input logic [3:0] w);
    logic [7:0] r;
    r = {sh[3:0], io};
    if (w == `LANES_ONE) begin
      r = {sh[6:0], io[0]};
    end else if (w == `LANES_TWO) begin
      r = {sh[5:0], io[1:0]};
    end
    return r;
  endfunction

  // is the address inside the zone guarded by the protection bits
  function automatic logic prot_hit(input logic [4:0] bp, input logic [23:0] a);
    logic [21:0] m;
    logic [21:0] hi;
    logic        r;
    m  = `ARRAY_ADDR_MASK << (`PROT_SHIFT_BASE + {1'b0, bp[3:0]});
    hi = a[21:0] & m;
    if (bp[3:0] == `PROT_NONE) begin
      r = 1'b0;
    end else if (bp[3:0] >= `PROT_ALL_MIN) begin
      r = 1'b1;
    end else begin
      r = bp[4] ? (hi == 22'h000000) : (hi == m);
    end
    return r;
  endfunction

  // self-timed length of each array operation
  function automatic logic [31:0] cycles_for(input arr_kind_t k);
    logic [31:0] r;
    case (k)
      ARR_WIPE_4K:  r = SMALL_WIPE_CYCLES;
      ARR_WIPE_32K: r = HALF_WIPE_CYCLES;
      ARR_WIPE_64K: r = LARGE_WIPE_CYCLES;
      ARR_WIPE_ALL: r = ARRAY_WIPE_CYCLES;
      default:      r = PROGRAM_CYCLES;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // link domain: serial shifter on the host clock
  logic        in_frame_ff;
  logic        frame_tgl_ff;
  logic [7:0]  sh_ff;
  logic [3:0]  bit_ff;
  logic [2:0]  idx_ff;
  logic [7:0]  opcode_ff;
  logic [23:0] addr_ff;
  logic [7:0]  ptr_ff;
  logic        data_any_ff;
  logic        qpi_ff;
  logic        qe_s1_ff;
  logic        qe_s2_ff;
  logic [255:0] valid_ff;
  logic [7:0]  page_buf [256];

  wire         frame_clr  = rst | cs_n;
  wire         first_edge = ~in_frame_ff;
  wire [3:0]   cur_bit    = first_edge ? 4'h0 : bit_ff;
  wire [2:0]   cur_idx    = first_edge ? `IDX_OPCODE : idx_ff;
  wire         dual_data  = (cur_idx == `IDX_DATA) && (opcode_ff == `OP_TWO_LINE_WRITE);
  // lane count: four in four line mode, two for two line data, else line 0 only
  wire [3:0]   lanes      = qpi_ff ? `LANES_FOUR : (dual_data ? `LANES_TWO : `LANES_ONE); // [RULE14] [RULE21] [RULE22]
  wire [7:0]   shifted    = shift_in(first_edge ? 8'h00 : sh_ff, io_lines, lanes); // [RULE24]
  wire [3:0]   nxt_bit    = cur_bit + lanes;
  wire         byte_done  = (nxt_bit == `BITS_PER_BYTE);

  // frame marker cleared while chip select is high
  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      in_frame_ff <= 1'b0;
    end else begin
      in_frame_ff <= 1'b1;
    end
  end

  // four line enable comes from another domain
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      qe_s1_ff <= 1'b0;
      qe_s2_ff <= 1'b0;
    end else begin
      qe_s1_ff <= four_line_enable;
      qe_s2_ff <= qe_s1_ff;
    end
  end

  // bit and byte counting, opcode and address capture
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      frame_tgl_ff <= 1'b0;
      sh_ff        <= 8'h00;
      bit_ff       <= 4'h0;
      idx_ff       <= `IDX_OPCODE;
      opcode_ff    <= 8'h00;
      addr_ff      <= 24'h000000;
      qpi_ff       <= 1'b0;
    end else begin
      frame_tgl_ff <= frame_tgl_ff ^ first_edge;
      sh_ff        <= shifted;
      bit_ff       <= byte_done ? 4'h0 : nxt_bit;
      idx_ff       <= cur_idx;
      if (byte_done && cur_idx != `IDX_DATA) begin
        idx_ff <= cur_idx + 3'd1;
      end
      if (byte_done && cur_idx == `IDX_OPCODE) begin
        opcode_ff <= shifted;
        // write latch lives elsewhere, so it survives the switch
        if (shifted == `OP_FOUR_LINE_ENTER && qe_s2_ff) begin
          qpi_ff <= 1'b1; // [RULE23]
        end else if (shifted == `OP_FOUR_LINE_EXIT) begin
          qpi_ff <= 1'b0; // [RULE23]
        end
      end
      if (byte_done && cur_idx != `IDX_OPCODE && cur_idx != `IDX_DATA) begin
        addr_ff <= {addr_ff[15:0], shifted}; // [RULE24]
      end
    end
  end

  // page buffer: wrapping pointer keeps the last 256 bytes at their offsets
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      ptr_ff      <= 8'h00;
      data_any_ff <= 1'b0;
      valid_ff    <= '0;
    end else if (byte_done && cur_idx == `IDX_ADDR_LAST) begin
      ptr_ff      <= shifted; // [RULE18]
      data_any_ff <= 1'b0;
      valid_ff    <= '0;
    end else if (byte_done && cur_idx == `IDX_DATA) begin
      ptr_ff           <= ptr_ff + 8'h01; // [RULE16] [RULE17]
      data_any_ff      <= 1'b1;
      valid_ff[ptr_ff] <= 1'b1;
    end
  end

  // page buffer storage
  always_ff @(posedge sclk) begin
    if (byte_done && cur_idx == `IDX_DATA) begin
      page_buf[ptr_ff] <= shifted;
    end
  end

  // frame snapshot; read only after chip select high, when sclk stands still
  frame_t lk;
  assign lk = '{opcode: opcode_ff, addr: addr_ff, idx: idx_ff, bits: bit_ff, data_any: data_any_ff};

  // ==========================================================================
  // core domain: synchronisers
  logic       cs_s1_ff;
  logic       cs_s2_ff;
  logic       cs_s3_ff;
  logic       tg_s1_ff;
  logic       tg_s2_ff;
  logic       seen_tgl_ff;
  logic [4:0] bp_s1_ff;
  logic [4:0] bp_s2_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
      tg_s1_ff <= 1'b0;
      tg_s2_ff <= 1'b0;
      bp_s1_ff <= 5'h00;
      bp_s2_ff <= 5'h00;
    end else if (ce) begin
      cs_s1_ff <= cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      tg_s1_ff <= frame_tgl_ff;
      tg_s2_ff <= tg_s1_ff;
      bp_s1_ff <= protection_bits;
      bp_s2_ff <= bp_s1_ff;
    end
  end

  // ==========================================================================
  // core domain: command decode at chip select rise
  seq_state_t  state_ff;
  seq_state_t  nxt_state;
  arr_kind_t   kind_ff;
  logic [23:0] base_ff;
  logic [7:0]  walk_ff;
  logic [31:0] timer_ff;
  logic        busy_ff;
  logic        latch_ff;
  logic        reject_ff;
  arr_op_t     op_ff;
  arr_op_t     nxt_op;

  wire cs_rise   = cs_s2_ff & ~cs_s3_ff;
  wire new_frame = cs_rise && (tg_s2_ff != seen_tgl_ff);
  wire aligned   = (lk.bits == 4'h0);
  wire end_addr  = aligned && (lk.idx == `IDX_DATA) && !lk.data_any;
  wire end_op    = aligned && (lk.idx == `IDX_AFTER_OPCODE);
  wire end_data  = aligned && (lk.idx == `IDX_DATA) && lk.data_any;
  wire is_write_enable_cmd   = (lk.opcode == WRITE_ENABLE_OPCODE);
  wire is_small  = (lk.opcode == `OP_SMALL_WIPE);
  wire is_half   = (lk.opcode == `OP_HALF_WIPE);
  wire is_large  = (lk.opcode == LARGE_WIPE_OPCODE);
  wire is_all    = (lk.opcode == ARRAY_WIPE_OPCODE);
  wire is_prog   = (lk.opcode == `OP_PAGE_WRITE) || (lk.opcode == `OP_TWO_LINE_WRITE);
  wire is_write  = is_small | is_half | is_large | is_all | is_prog;
  // frame must close exactly on the last byte the command needs
  wire frame_ok  = ((is_small | is_half | is_large) & end_addr) | (is_all & end_op) | (is_prog & end_data); // [RULE4] [RULE12] [RULE15]
  wire protected_hit = is_all ? (bp_s2_ff[3:0] != `PROT_NONE) : prot_hit(bp_s2_ff, lk.addr); // [RULE6] [RULE13]
  wire idle      = (state_ff == ST_IDLE);
  wire accept    = new_frame && idle && is_write && frame_ok && latch_ff; // [RULE1]
  wire start_cmd = accept && !protected_hit;
  wire refuse    = new_frame && idle && is_write && !accept; // [RULE25]
  wire write_enable_cmd_ok   = new_frame && idle && is_write_enable_cmd && end_op;

  // region kind and aligned base of the accepted command
  wire arr_kind_t cmd_kind =
    is_small ? ARR_WIPE_4K : is_half ? ARR_WIPE_32K : is_large ? ARR_WIPE_64K : is_all ? ARR_WIPE_ALL : ARR_PROG;
  wire [23:0] cmd_base =
    is_small ? {lk.addr[23:`SECTOR_LSB], 12'h000} : // [RULE3]
    is_half  ? {lk.addr[23:`HALF_LSB], 15'h0000} : // [RULE7]
    is_large ? {lk.addr[23:`LARGE_LSB], 16'h0000} : // [RULE10]
    is_all   ? 24'h000000 : {lk.addr[23:`PAGE_LSB], 8'h00};
  wire        walk_last = (walk_ff == `PAGE_LAST);
  wire        timer_end = (timer_ff == 32'h00000001);

  // ==========================================================================
  // sequencer next state and array request
  always_comb begin
    nxt_state = state_ff;
    nxt_op    = '{valid: 1'b0, kind: ARR_NONE, addr: 24'h000000, data: 8'h00};
    case (state_ff)
      ST_IDLE: begin
        if (start_cmd) begin
          nxt_state = is_prog ? ST_PROG : ST_ERASE;
        end
      end
      ST_ERASE: begin
        // region goes to all ones
        nxt_op    = '{valid: 1'b1, kind: kind_ff, addr: base_ff, data: 8'hff}; // [RULE2]
        nxt_state = ST_WAIT;
      end
      ST_PROG: begin
        // array ands the byte in, so only zeros are written
        if (valid_ff[walk_ff]) begin
          nxt_op = '{valid: 1'b1, kind: ARR_PROG, addr: {base_ff[23:8], walk_ff}, data: page_buf[walk_ff]}; // [RULE2]
        end
        if (walk_last) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (timer_end) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state, request register and frame bookkeeping
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff    <= ST_IDLE;
      op_ff       <= '0;
      reject_ff   <= 1'b0;
      seen_tgl_ff <= 1'b0;
    end else if (ce) begin
      state_ff  <= nxt_state;
      op_ff     <= nxt_op;
      reject_ff <= refuse;
      if (cs_rise) begin
        seen_tgl_ff <= tg_s2_ff;
      end
    end
  end

  // command capture, page walk and self-timer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kind_ff  <= ARR_NONE;
      base_ff  <= 24'h000000;
      walk_ff  <= 8'h00;
      timer_ff <= 32'h00000000;
    end else if (ce) begin
      if (start_cmd) begin
        kind_ff  <= cmd_kind;
        base_ff  <= cmd_base;
        walk_ff  <= 8'h00;
        timer_ff <= cycles_for(cmd_kind); // [RULE5] [RULE8] [RULE11] [RULE13] [RULE19]
      end else if (state_ff == ST_PROG) begin
        walk_ff <= walk_ff + 8'h01;
      end else if (state_ff == ST_WAIT) begin
        timer_ff <= timer_ff - 32'h00000001;
      end
    end
  end

  // busy flag and write latch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_ff  <= 1'b0;
      latch_ff <= 1'b0;
    end else if (ce) begin
      if (start_cmd) begin
        busy_ff <= 1'b1; // [RULE5] [RULE19]
      end else if (state_ff == ST_DONE) begin
        busy_ff  <= 1'b0;
        latch_ff <= 1'b0; // [RULE8] [RULE11]
      end
      if (write_enable_cmd_ok) begin
        latch_ff <= 1'b1; // [RULE1]
      end else if (accept && protected_hit) begin
        latch_ff <= 1'b0; // [RULE9]
      end
    end
  end

  assign busy_flag      = busy_ff;
  assign write_latch    = latch_ff;
  assign four_line_mode = qpi_ff;
  assign cmd_reject     = reject_ff;
  assign arr_op         = op_ff;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [31:0] busy_len_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_len_ff <= 32'h00000000;
    end else if (ce) begin
      busy_len_ff <= busy_ff ? busy_len_ff + 32'h00000001 : 32'h00000000;
    end
  end

  sequence s_erase_issue;
    op_ff.valid && (op_ff.kind != ARR_PROG) && (op_ff.kind != ARR_NONE);
  endsequence
  sequence s_busy_two;
    busy_ff ##1 busy_ff;
  endsequence

  chk_erase_busy_hold: assert property (s_erase_issue |-> s_busy_two) // [RULE2]
    else $error("erase issued without busy held");
  chk_start_needs_latch: assert property (start_cmd |-> latch_ff && frame_ok) // [RULE1]
    else $error("write started without write latch");
  chk_small_wipe_len: assert property ($fell(busy_ff) && kind_ff == ARR_WIPE_4K |->
      busy_len_ff == SMALL_WIPE_CYCLES + 32'd2) // [RULE5]
    else $error("sector wipe busy length wrong");
  chk_half_wipe_len: assert property ($fell(busy_ff) && kind_ff == ARR_WIPE_32K |->
      busy_len_ff == HALF_WIPE_CYCLES + 32'd2 && !latch_ff) // [RULE8]
    else $error("half wipe length or latch wrong");
  chk_large_wipe_len: assert property ($fell(busy_ff) && kind_ff == ARR_WIPE_64K |->
      busy_len_ff == LARGE_WIPE_CYCLES + 32'd2) // [RULE11]
    else $error("large wipe busy length wrong");
  chk_array_wipe_open: assert property (start_cmd && is_all |-> bp_s2_ff[3:0] == `PROT_NONE) // [RULE13]
    else $error("array wipe started while protected");
  chk_prog_len: assert property ($fell(busy_ff) && kind_ff == ARR_PROG |->
      busy_len_ff == PROGRAM_CYCLES + 32'd257 && !latch_ff) // [RULE19]
    else $error("page write busy length wrong");
  chk_prog_in_page: assert property (op_ff.valid && op_ff.kind == ARR_PROG |->
      op_ff.addr[23:8] == base_ff[23:8]) // [RULE16]
    else $error("program byte outside its page");
  chk_sector_align: assert property (op_ff.valid && (op_ff.kind == ARR_WIPE_4K) |->
      op_ff.addr[11:0] == 12'h000) // [RULE3]
    else $error("sector base not aligned");
  chk_reject_keeps: assert property (refuse && !(latch_ff && frame_ok) |=>
      $stable(latch_ff) && !busy_ff && reject_ff) // [RULE25]
    else $error("rejected command changed state");
  chk_wipe_frame_end: assert property (start_cmd && (is_small || is_half || is_large) |->
      lk.idx == `IDX_DATA && lk.bits == 4'h0) // [RULE4]
    else $error("wipe accepted off the address boundary");

endmodule

// *** pkg/flash_seq_defines.svh ***
// constants for the flash erase and program command sequencer
// ==========================================================================
// Contract
// RULE1 - write latch must be set before writing
// RULE2 - erase sets bits, program only clears
// RULE3 - sector wipe: opcode 20, sector from A12 up
// RULE4 - wipe frame must end on final address byte
// RULE5 - sector wipe timed, busy held, latch cleared
// RULE6 - protected sector is never erased
// RULE7 - half wipe: opcode 52 erases 32K block
// RULE8 - half wipe timed, busy held, latch cleared
// RULE9 - protected 32K block unchanged, latch still cleared
// RULE10 - large wipe erases one 64K block
// RULE11 - large wipe timed, clears flags, skips protected
// RULE12 - array wipe is opcode alone, byte aligned
// RULE13 - array wipe only when unprotected, timed
// RULE14 - page write: 02, address, data on line 0
// RULE15 - page write frame ends on data byte boundary
// RULE16 - data past page end wraps to offset 0
// RULE17 - over 256 bytes keeps only last 256
// RULE18 - short writes land at their own offsets
// RULE19 - page write timed, clears flags, skips protected
// RULE20 - host should write whole aligned pages once
// RULE21 - two line write: A2, data on lines 1:0
// RULE22 - all writes also accepted in four line mode
// RULE23 - 38 enters four line mode, FF leaves it; the code enters only while four_line_enable is set
// RULE24 - msb first on rising clock, address high first
// RULE25 - rejected command changes nothing
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH
// ==========================================================================
// opcodes
`define OP_SMALL_WIPE      8'h20
`define OP_HALF_WIPE       8'h52
`define OP_PAGE_WRITE      8'h02
`define OP_TWO_LINE_WRITE  8'ha2
`define OP_FOUR_LINE_ENTER 8'h38
`define OP_FOUR_LINE_EXIT  8'hff
// ==========================================================================
// frame shape
`define BITS_PER_BYTE      4'd8
`define LANES_ONE          4'd1
`define LANES_TWO          4'd2
`define LANES_FOUR         4'd4
`define IDX_OPCODE         3'd0
`define IDX_ADDR_LAST      3'd3
`define IDX_DATA           3'd4
`define IDX_AFTER_OPCODE   3'd1
// ==========================================================================
// address fields and protection decode
`define SECTOR_LSB         12
`define HALF_LSB           15
`define LARGE_LSB          16
`define PAGE_LSB           8
`define PAGE_LAST          8'hff
`define PROT_NONE          4'h0
`define PROT_ALL_MIN       4'h7
`define PROT_SHIFT_BASE    5'd15
`define ARRAY_ADDR_MASK    22'h3fffff
// ==========================================================================
// self-timed durations in microseconds, and clock rate
`define REF_CLK_MHZ        32'd250
`define SMALL_WIPE_TIME_US 32'd45000
`define HALF_WIPE_TIME_US  32'd120000
`define LARGE_WIPE_TIME_US 32'd150000
`define ARRAY_WIPE_TIME_US 32'd8000000
`define PROGRAM_TIME_US    32'd400
`endif

// *** pkg/flash_seq_pkg.sv ***
// types shared by the flash erase and program command sequencer
package flash_seq_pkg;
  // ==========================================================================
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ERASE = 5'b00010,
    ST_PROG  = 5'b00100,
    ST_WAIT  = 5'b01000,
    ST_DONE  = 5'b10000
  } seq_state_t;
  // ==========================================================================
  // array operation kinds
  typedef enum logic [2:0] {
    ARR_NONE     = 3'h0,
    ARR_WIPE_4K  = 3'h1,
    ARR_WIPE_32K = 3'h2,
    ARR_WIPE_64K = 3'h3,
    ARR_WIPE_ALL = 3'h4,
    ARR_PROG     = 3'h5
  } arr_kind_t;
  // one array request: erase a region or and-in a byte
  typedef struct packed {
    logic        valid;
    arr_kind_t   kind;
    logic [23:0] addr;
    logic [7:0]  data;
  } arr_op_t;
  // snapshot of a serial frame, stable once chip select is high
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [2:0]  idx;
    logic [3:0]  bits;
    logic        data_any;
  } frame_t;
endpackage

// *** test/host_model.sv ***
// host side model of a serial flash controller
`timescale 1ns/100ps
module host_model (
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] io_lines
);
  // ==========================================================================
  // idle: link clock parked low, device deselected
  initial begin
    sclk     = 1'b0;
    cs_n     = 1'b1;
    io_lines = 4'h0;
  end
  // one frame: first four bytes on cl lanes, data on dl lanes, then stray bits
  task automatic send(input logic [7:0] b[$], input int cl, input int dl, input int extra);
    int         ln;
    logic [7:0] v;
    cs_n = 1'b0;
    #6;
    for (int i = 0; i < b.size(); i++) begin
      ln = (i < 4) ? cl : dl;
      v  = b[i];
      for (int k = 0; k < 8; k += ln) begin
        io_lines = ~io_lines; // unused lanes never hold a steady value
        for (int j = 0; j < ln; j++) io_lines[ln-1-j] = v[7-k-j]; // msb first
        #6 sclk = 1'b1;
        #6 sclk = 1'b0;
      end
    end
    repeat (extra) begin
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1; // rise right after the last bit
    io_lines = ~io_lines; // released lines do not keep the last level
  endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench of the flash erase and program sequencer
`timescale 1ns/100ps
module testbench;
  import flash_seq_pkg::*;
  localparam int unsigned CYC = 20;
  localparam logic [7:0]  WEN = 8'h06;
  logic       ref_clk, rst, ce, sclk, cs_n, four_line_enable;
  logic [3:0] io_lines;
  logic [4:0] protection_bits;
  logic       busy_flag, write_latch, four_line_mode, cmd_reject;
  arr_op_t    arr_op;
  arr_op_t    ops[$];
  int         errors, n_tests, n_rej, n_busy;
  int         seed = 32'h94715232;
  logic [7:0]  op[4] = '{8'h20, 8'h52, 8'hd8, 8'h60};
  logic [23:0] msk[4] = '{24'h000fff, 24'h007fff, 24'h00ffff, 24'hffffff};
  arr_kind_t   kind[4] = '{ARR_WIPE_4K, ARR_WIPE_32K, ARR_WIPE_64K, ARR_WIPE_ALL};
  logic [7:0]  off[3] = '{8'hfe, 8'h37, 8'h00};
  int          cnt[3] = '{3, 258, 1};
  int          pln[3] = '{1, 2, 1};

  flash_seq #(.WRITE_ENABLE_OPCODE(WEN), .LARGE_WIPE_OPCODE(8'hd8), .ARRAY_WIPE_OPCODE(8'h60),
    .SMALL_WIPE_CYCLES(CYC), .HALF_WIPE_CYCLES(CYC), .LARGE_WIPE_CYCLES(CYC),
    .ARRAY_WIPE_CYCLES(CYC), .PROGRAM_CYCLES(CYC)) i_flash_seq (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .io_lines(io_lines),
    .four_line_enable(four_line_enable), .protection_bits(protection_bits),
    .busy_flag(busy_flag), .write_latch(write_latch), .four_line_mode(four_line_mode),
    .cmd_reject(cmd_reject), .arr_op(arr_op));

  host_model host (.sclk(sclk), .cs_n(cs_n), .io_lines(io_lines));

  // ==========================================================================
  // core clock, 4 ns
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // collect array requests, refusals and busy cycles
  always @(posedge ref_clk) begin
    if (arr_op.valid === 1'b1) ops.push_back(arr_op);
    if (cmd_reject === 1'b1) n_rej++;
    if (busy_flag === 1'b1) n_busy++;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one frame, then wait for any self-timed cycle under a bound
  task automatic run(input logic [7:0] b[$], input int cl, input int dl, input int ex);
    ops    = {};
    n_rej  = 0;
    n_busy = 0;
    host.send(b, cl, dl, ex);
    repeat (8) @(posedge ref_clk);
    for (int t = 0; t < 2000 && busy_flag !== 1'b0; t++) @(posedge ref_clk);
    if (busy_flag !== 1'b0) begin
      errors++;
      results();
    end
    repeat (6) @(posedge ref_clk);
  endtask

  // watchdog
  initial begin
    #300000;
    errors++;
    results();
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [7:0]  b[$];
    logic [23:0] a;
    logic [7:0]  d;
    logic [8:0]  exp[256];
    int          ln, k;
    ce = 1'b1;
    rst = 1'b1;
    four_line_enable = 1'b0;
    protection_bits = 5'h00;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    check(write_latch, 0);
    // every wipe kind, single line then four line mode
    for (int q = 0; q < 2; q++) begin
      ln = q ? 4 : 1;
      for (int w = 0; w < 4; w++) begin
        a = $random(seed) & 24'h3fffff;
        b = {op[w]};
        if (w < 3) b = {b, a[23:16], a[15:8], a[7:0]};
        run('{WEN}, ln, ln, 0);
        check(write_latch, 1);
        run(b, ln, ln, 0);
        check(ops.size(), 1);
        check(ops[0], {1'b1, kind[w], a & ~msk[w], 8'hff});
        check(n_busy, CYC + 2);
        check(write_latch, 0);
      end
      if (q == 0) begin
        run('{8'h38}, 1, 1, 0);
        check(four_line_mode, 0);
        @(negedge ref_clk) four_line_enable = 1'b1;
        run('{8'h38}, 1, 1, 0);
        check(four_line_mode, 1);
      end
    end
    run('{8'hff}, 4, 4, 0);
    check(four_line_mode, 0);
    // refusals: clear latch, bad framing
    b = {8'h20, 8'h01, 8'h23, 8'h45};
    run(b, 1, 1, 0);
    check({n_rej, n_busy, ops.size()}, {32'd1, 32'd0, 32'd0});
    run('{WEN}, 1, 1, 0);
    run(b, 1, 1, 1);
    check({n_rej, n_busy, write_latch}, {32'd1, 32'd0, 1'b1});
    run({8'h02, b[1], b[2], b[3], 8'h5a}, 1, 1, 3);
    check({n_rej, ops.size(), write_latch}, {32'd1, 32'd0, 1'b1});
    // protected targets
    @(negedge ref_clk) protection_bits = 5'h07;
    run(b, 1, 1, 0);
    check({n_rej, n_busy, ops.size(), write_latch}, 97'h0);
    @(negedge ref_clk) protection_bits = 5'h01;
    run('{WEN}, 1, 1, 0);
    run('{8'h60}, 1, 1, 0);
    check({n_busy, ops.size(), write_latch}, 65'h0);
    @(negedge ref_clk) protection_bits = 5'h00;
    // page writes: wrap, overlong two line, single byte
    for (int p = 0; p < 3; p++) begin
      a = ($random(seed) & 24'h3fff00) | off[p];
      b = {(p == 1) ? 8'ha2 : 8'h02, a[23:16], a[15:8], a[7:0]};
      for (int i = 0; i < 256; i++) exp[i] = 9'h000;
      for (int i = 0; i < cnt[p]; i++) begin
        d = $random(seed);
        b.push_back(d);
        exp[8'(a[7:0] + 8'(i))] = {1'b1, d};
      end
      run('{WEN}, 1, 1, 0);
      run(b, 1, pln[p], 0); // unaligned and overlong pages on purpose
      k = 0;
      for (int i = 0; i < 256; i++) begin
        if (exp[i][8]) begin
          check(ops[k], {1'b1, ARR_PROG, a[23:8], 8'(i), exp[i][7:0]});
          k++;
        end
      end
      check(ops.size(), k);
      check({n_busy, write_latch}, {CYC + 257, 1'b0});
    end
    results();
  end
endmodule
